/* File: logic/rcv_cfg_pkg.sv */
// Package: constants and types for receiver config and wake control
package rcv_cfg_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] cmd_off = 12'h000;
  localparam logic [11:0] key_off = 12'h004;
  localparam logic [11:0] val_off = 12'h008;
  localparam logic [11:0] reply_off = 12'h00C;
  localparam logic [11:0] rate_off = 12'h010;
  localparam logic [11:0] outprot_off = 12'h014;
  localparam logic [11:0] info_off = 12'h018;
  localparam logic [11:0] event_off = 12'h01C;
  localparam logic [11:0] power_off = 12'h020;
  localparam logic [11:0] status_off = 12'h024;
  localparam logic [11:0] nvm_off = 12'h028;

  // ----------------------------------------------------------------------
  // Configuration keys (item index inside the store)
  // ----------------------------------------------------------------------
  localparam int num_keys = 12;
  localparam logic [3:0] key_centre_freq = 4'h0;
  localparam logic [3:0] key_search_span = 4'h1;
  localparam logic [3:0] key_service_filter = 4'h2;
  localparam logic [3:0] key_service_id = 4'h3;
  localparam logic [3:0] key_bit_rate = 4'h4;
  localparam logic [3:0] key_descramble = 4'h5;
  localparam logic [3:0] key_seed = 4'h6;
  localparam logic [3:0] key_sync_err = 4'h7;
  localparam logic [3:0] key_prescramble = 4'h8;
  localparam logic [3:0] key_sync_lo = 4'h9;
  localparam logic [3:0] key_sync_hi = 4'hA;
  localparam logic [3:0] key_serial_baud = 4'hB;

  // ----------------------------------------------------------------------
  // Defaults and limits
  // ----------------------------------------------------------------------
  localparam logic [31:0] def_centre_freq = 32'd1539812500;
  localparam logic [31:0] def_search_span = 32'd2200;
  localparam logic [31:0] def_service_filter = 32'h0000_0001;
  localparam logic [31:0] def_service_id = 32'd50821;
  localparam logic [31:0] def_bit_rate = 32'd2400;
  localparam logic [31:0] def_descramble = 32'h0000_0001;
  localparam logic [31:0] def_seed = 32'd23560;
  localparam logic [31:0] def_sync_err = 32'd4;
  localparam logic [31:0] def_prescramble = 32'h0000_0000;
  localparam logic [31:0] def_sync_lo = 32'hE15AE893;
  localparam logic [31:0] def_sync_hi = 32'hE15AE893;
  localparam logic [31:0] def_serial_baud = 32'd9600;
  localparam logic [31:0] min_centre_freq = 32'd1525000000;
  localparam logic [31:0] max_centre_freq = 32'd1559000000;
  localparam logic [31:0] min_bit_rate = 32'd600;
  localparam logic [31:0] max_bit_rate = 32'd4800;

  // Serial framing defaults: 8 data bits, no parity, 1 stop bit
  localparam logic [3:0] def_data_bits = 4'h8;
  localparam logic [1:0] def_stop_bits = 2'h1;
  localparam logic def_parity_on = 1'b0;

  // Four interfaces: serial1, usb, two-wire, four-wire
  localparam int num_ports = 4;
  // Output protocol default: binary protocol on every interface
  localparam logic [3:0] def_outprot = 4'hF;
  localparam logic [3:0] def_inprot = 4'hF;

  // ----------------------------------------------------------------------
  // Commands and timing
  // ----------------------------------------------------------------------
  localparam logic [2:0] cmd_set = 3'h1;
  localparam logic [2:0] cmd_get = 3'h2;
  localparam logic [2:0] cmd_delete = 3'h3;
  localparam logic [2:0] cmd_version_poll = 3'h4;
  localparam logic [2:0] cmd_power_request = 3'h5;

  localparam int clk_hz = 20_000_000;
  localparam int ms_per_tick = 1;
  localparam int ms_cycles = clk_hz / 1000 * ms_per_tick;

  typedef enum logic [1:0] {
    pwr_acquire = 2'b00,
    pwr_track = 2'b01,
    pwr_inactive = 2'b11
  } pwr_state_t;

endpackage : rcv_cfg_pkg

/* File: logic/wake_sync.sv */
// Synchroniser and edge detector for the wake pins
`timescale 1ns/1ps
module wake_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] pins,
  input wire logic [3:0] rise_en,
  input wire logic [3:0] fall_en,
  output logic wake_evt
);
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic [3:0] prev_r;

  // Pin levels settle through two flops before any edge logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 4'h0;
      sync_r <= 4'h0;
      prev_r <= 4'h0;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign wake_evt = |((sync_r & ~prev_r & rise_en) |
                      (~sync_r & prev_r & fall_en));
endmodule : wake_sync

/* File: logic/rcv_cfg_wake.sv */
// Receiver configuration store, message gating and wake control
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// How it works
// - every set, get or delete command gets an ack or nak reply
// - startup store is defaults overlaid by nonvolatile settings
// - configuration held as separate key and value items
// - correction channel defaults loaded from package constants
// - serial port defaults 9600 8N1, binary protocol in and out
// - zero rate never emits; nonzero rate counts related events
// - each message rate kept separately per interface
// - version report emitted only in reply to a poll
// - info text has per-interface enable, no rate
// - nothing leaves an interface unless its output protocol enabled
// - centre frequency accepted by set only within 1525 to 1559 MHz; nvm overlay not range checked
// - correction bit rate accepted by set only within 600 to 4800 bps; nvm overlay not range checked
// - one raw correction message per detected service frame
// - only continuous and commanded backup power schemes exist
// - power request enters inactive until timeout or wake event
// - wake on either edge of interrupts or serial rx, reset rise
// - wake starts acquisition; ignored while acquiring or tracking
// - usb host attached keeps processing alive, no deepest state
module rcv_cfg_wake (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] ext_interrupt_pin,
  input wire logic primary_serial_rx,
  input wire logic reset_pin_low,
  input wire logic usb_host_attached,
  input wire logic frame_detected,
  input wire logic [3:0] msg_event,
  output logic [3:0] raw_correction_msg,
  output logic [3:0] periodic_msg,
  output logic [3:0] version_report_msg,
  output logic [3:0] info_text_msgs,
  output logic ack_reply,
  output logic nak_reply,
  output logic [31:0] channel_centre_freq,
  output logic [15:0] correction_bit_rate,
  output logic [15:0] service_identifier,
  output logic service_filter_on,
  output logic descramble_on,
  output logic prescramble_on,
  output logic [1:0] power_state,
  output logic core_clock_gate
);
  import rcv_cfg_pkg::*;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic wr_acc;
  assign wr_acc = psel & penable & pwrite;

  // ----------------------------------------------------------------------
  // Configuration store
  // ----------------------------------------------------------------------
  logic [31:0] store_r [num_keys], nvm_r [num_keys];
  logic [num_keys-1:0] nvm_valid_r;
  logic [3:0] rate_r [num_ports], cnt_r [num_ports];
  logic [3:0] key_r, outprot_r, info_en_r, inprot_r, data_bits_r;
  logic [31:0] val_r, get_val_r, power_dur_r, power_cnt_r;
  logic [1:0] reply_r, stop_bits_r;
  logic [2:0] cmd_code;
  logic [15:0] ms_cnt_r;
  logic parity_on_r, boot_done_r, cmd_go, key_ok, val_ok, ms_tick, wake_evt;
  pwr_state_t pwr_r;

  // Built-in settings: reset loads them and delete restores them
  localparam logic [31:0] def_tab [num_keys] = '{def_centre_freq,
    def_search_span, def_service_filter, def_service_id, def_bit_rate,
    def_descramble, def_seed, def_sync_err, def_prescramble, def_sync_lo,
    def_sync_hi, def_serial_baud};

  assign cmd_go = wr_acc && (paddr == cmd_off);
  assign cmd_code = pwdata[2:0];
  assign key_ok = (key_r < 4'(num_keys));

  // Range checks only apply to the two bounded keys
  always_comb begin
    val_ok = 1'b1;
    if (key_r == key_centre_freq) begin
      val_ok = (val_r >= min_centre_freq) &&
               (val_r <= max_centre_freq);
    end else if (key_r == key_bit_rate) begin
      val_ok = (val_r >= min_bit_rate) &&
               (val_r <= max_bit_rate);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_r <= 4'h0;
      val_r <= 32'h0000_0000;
      power_dur_r <= 32'h0000_0000;
    end else if (wr_acc && paddr == key_off) begin
      key_r <= pwdata[3:0];
    end else if (wr_acc && paddr == val_off) begin
      val_r <= pwdata;
    end else if (wr_acc && paddr == power_off) begin
      power_dur_r <= pwdata;
    end
  end

  // Nonvolatile shadow: key in [27:24], bit 31 clears the entry. No reset
  // on purpose, so saved items survive presetn and reach the overlay.
  always_ff @(posedge pclk) begin
    if (wr_acc && paddr == nvm_off && pwdata[27:24] < 4'(num_keys)) begin
      nvm_valid_r[pwdata[27:24]] <= ~pwdata[31];
      nvm_r[pwdata[27:24]] <= val_r;
    end
  end

  generate
    for (genvar k = 0; k < num_keys; k++) begin : g_item
      // Reset loads defaults; the first cycle after release overlays nvm
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          store_r[k] <= def_tab[k];
        end else if (!boot_done_r) begin
          if (nvm_valid_r[k]) begin
            store_r[k] <= nvm_r[k];
          end
        end else if (cmd_go && key_ok && key_r == 4'(k)) begin
          if (cmd_code == cmd_set && val_ok) begin
            store_r[k] <= val_r;
          end else if (cmd_code == cmd_delete) begin
            store_r[k] <= def_tab[k];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_done_r <= 1'b0;
    end else begin
      boot_done_r <= 1'b1;
    end
  end

  // Command reply: ack for a good item, nak otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reply <= 1'b0;
      nak_reply <= 1'b0;
      reply_r <= 2'b00;
      get_val_r <= 32'h0000_0000;
    end else begin
      ack_reply <= 1'b0;
      nak_reply <= 1'b0;
      if (cmd_go && (cmd_code == cmd_set || cmd_code == cmd_get ||
                     cmd_code == cmd_delete)) begin
        if (key_ok && (cmd_code != cmd_set || val_ok)) begin
          ack_reply <= 1'b1;
          reply_r <= 2'b01;
          if (cmd_code == cmd_get) begin
            get_val_r <= store_r[key_r];
          end
        end else begin
          nak_reply <= 1'b1;
          reply_r <= 2'b10;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interface settings
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outprot_r <= def_outprot;
      inprot_r <= def_inprot;
      data_bits_r <= def_data_bits;
      stop_bits_r <= def_stop_bits;
      parity_on_r <= def_parity_on;
      info_en_r <= 4'h0;
    end else if (wr_acc && paddr == outprot_off) begin
      outprot_r <= pwdata[3:0];
      inprot_r <= pwdata[7:4];
    end else if (wr_acc && paddr == info_off) begin
      info_en_r <= pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // Per-interface rate dividers and output gating
  // ----------------------------------------------------------------------
  generate
    for (genvar p = 0; p < num_ports; p++) begin : g_port
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rate_r[p] <= 4'h0;
        end else if (wr_acc && paddr == rate_off) begin
          rate_r[p] <= pwdata[4*p +: 4];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_r[p] <= 4'h0;
          periodic_msg[p] <= 1'b0;
        end else begin
          periodic_msg[p] <= 1'b0;
          if (rate_r[p] == 4'h0) begin
            cnt_r[p] <= 4'h0;
          end else if (msg_event[p]) begin
            if (cnt_r[p] + 4'h1 >= rate_r[p]) begin
              cnt_r[p] <= 4'h0;
              periodic_msg[p] <= outprot_r[p];
            end else begin
              cnt_r[p] <= cnt_r[p] + 4'h1;
            end
          end
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          raw_correction_msg[p] <= 1'b0;
          version_report_msg[p] <= 1'b0;
          info_text_msgs[p] <= 1'b0;
        end else begin
          raw_correction_msg[p] <= frame_detected &
                                   outprot_r[p];
          version_report_msg[p] <= cmd_go &&
                                   cmd_code == cmd_version_poll &&
                                   outprot_r[p];
          info_text_msgs[p] <= cmd_go && cmd_code == cmd_version_poll &&
                               info_en_r[p] && outprot_r[p];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Power control
  // ----------------------------------------------------------------------
  // Edges are qualified after two flops; reset pin wakes on rising only
  wake_sync u_wake (
    .pclk(pclk),
    .presetn(presetn),
    .pins({reset_pin_low, primary_serial_rx, ext_interrupt_pin}),
    .rise_en(4'hF),
    .fall_en(4'h7),
    .wake_evt(wake_evt)
  );

  assign ms_tick = (ms_cnt_r == 16'(ms_cycles - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_r <= 16'h0000;
    end else if (pwr_r != pwr_inactive || ms_tick) begin
      ms_cnt_r <= 16'h0000;
    end else begin
      ms_cnt_r <= ms_cnt_r + 16'h0001;
    end
  end

  // Duration in ms; zero means stay until a wake event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_r <= pwr_acquire;
      power_cnt_r <= 32'h0000_0000;
    end else begin
      case (pwr_r)
        pwr_acquire, pwr_track: begin
          if (cmd_go && cmd_code == cmd_power_request) begin
            pwr_r <= pwr_inactive;
            power_cnt_r <= power_dur_r;
          end else if (frame_detected) begin
            pwr_r <= pwr_track;
          end
        end
        pwr_inactive: begin
          if (wake_evt) begin
            pwr_r <= pwr_acquire;
          end else if (ms_tick && power_cnt_r != 32'h0000_0000) begin
            if (power_cnt_r == 32'h0000_0001) begin
              pwr_r <= pwr_acquire;
            end
            power_cnt_r <= power_cnt_r - 32'h0000_0001;
          end
        end
        default: pwr_r <= pwr_acquire;
      endcase
    end
  end

  // Gate the core clock only when no usb host needs servicing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_clock_gate <= 1'b0;
      power_state <= 2'b00;
    end else begin
      core_clock_gate <= (pwr_r == pwr_inactive) &&
                         !usb_host_attached;
      power_state <= pwr_r;
    end
  end

  // ----------------------------------------------------------------------
  // Config outputs and read mux
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_centre_freq <= def_centre_freq;
      correction_bit_rate <= def_bit_rate[15:0];
      service_identifier <= def_service_id[15:0];
      service_filter_on <= def_service_filter[0];
      descramble_on <= def_descramble[0];
      prescramble_on <= def_prescramble[0];
    end else begin
      channel_centre_freq <= store_r[key_centre_freq];
      correction_bit_rate <= store_r[key_bit_rate][15:0];
      service_identifier <= store_r[key_service_id][15:0];
      service_filter_on <= store_r[key_service_filter][0];
      descramble_on <= store_r[key_descramble][0];
      prescramble_on <= store_r[key_prescramble][0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          key_off: prdata <= {28'h0, key_r};
          val_off: prdata <= get_val_r;
          reply_off: prdata <= {30'h0, reply_r};
          rate_off: prdata <= {16'h0, rate_r[3], rate_r[2],
                               rate_r[1], rate_r[0]};
          outprot_off: prdata <= {24'h0, inprot_r, outprot_r};
          info_off: prdata <= {28'h0, info_en_r};
          power_off: prdata <= power_dur_r;
          status_off: prdata <= {21'h0, parity_on_r, stop_bits_r,
                                 data_bits_r, usb_host_attached,
                                 boot_done_r, pwr_r};
          nvm_off: prdata <= {20'h0, nvm_valid_r};
          cmd_off, event_off: prdata <= 32'h0000_0000;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule : rcv_cfg_wake

/* File: dv/rcv_cfg_checker.sv */
// Checker: port-level properties of the receiver config block
`timescale 1ns/1ps
module rcv_cfg_checker
  import rcv_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_detected,
  input wire logic [3:0] raw_correction_msg,
  input wire logic ack_reply,
  input wire logic nak_reply,
  input wire logic usb_host_attached,
  input wire logic core_clock_gate,
  input wire logic [1:0] power_state,
  input wire logic [31:0] channel_centre_freq,
  input wire logic [15:0] correction_bit_rate
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_pready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access cycle");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_reply_single: assert property (!(ack_reply && nak_reply))
    else $error("ack and nak together");
  a_raw_cause: assert property (raw_correction_msg != 4'h0
    |-> $past(frame_detected)) else $error("raw output without frame");
  a_raw_lone: assert property (raw_correction_msg != 4'h0
    && !frame_detected |=> raw_correction_msg == 4'h0)
    else $error("raw output repeated");
  a_gate_usb: assert property (usb_host_attached
    && $past(usb_host_attached) |-> !core_clock_gate)
    else $error("deep sleep with usb host");
  a_gate_sleep: assert property (core_clock_gate |->
    power_state == pwr_inactive || $past(power_state) == pwr_inactive)
    else $error("clock gated while awake");
  a_freq_range: assert property (channel_centre_freq >=
    min_centre_freq && channel_centre_freq <= max_centre_freq)
    else $error("centre frequency out of range");
  a_rate_range: assert property (correction_bit_rate >= 16'h0258
    && correction_bit_rate <= 16'h12C0) else $error("bit rate out of range");
  a_wake_acquire: assert property ($past(power_state) ==
    pwr_inactive && power_state != pwr_inactive |->
    power_state == pwr_acquire) else $error("wake not to acquire");
  c_ack: cover property (ack_reply);
  c_nak: cover property (nak_reply);
  c_sleep: cover property (power_state == pwr_inactive);
endmodule : rcv_cfg_checker

bind rcv_cfg_wake rcv_cfg_checker i_rcv_cfg_checker (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .frame_detected, .raw_correction_msg,
  .ack_reply, .nak_reply, .usb_host_attached, .core_clock_gate,
  .power_state, .channel_centre_freq, .correction_bit_rate);

/* File: dv/host_apb_model.sv */
// Host model: APB master issuing configuration commands
`timescale 1ns/1ps
module host_apb_model
  import rcv_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Hold the request until pready is seen high at a rising edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : xfer

  task automatic command(input logic [3:0] k, input logic [31:0] v,
      input logic [2:0] c, output logic [31:0] r);
    logic e;
    xfer(1'h1, key_off, {28'h0, k}, r, e);
    xfer(1'h1, val_off, v, r, e);
    xfer(1'h1, cmd_off, {29'h0, c}, r, e);
    xfer(1'h0, reply_off, 32'h0, r, e);
  endtask : command
endmodule : host_apb_model

/* File: dv/receiver_config_and_wake_control_bench.sv */
// Self-checking bench for the receiver config and wake block
`timescale 1ns/1ps
module receiver_config_and_wake_control_bench;
  import rcv_cfg_pkg::*;
  typedef struct {logic [3:0] k; logic [31:0] v; logic [1:0] r;
    logic [31:0] f; logic [15:0] b;} row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, clr;
  logic usb_host_attached, frame_detected;
  logic service_filter_on, descramble_on, prescramble_on, core_clock_gate;
  logic ack_reply, nak_reply;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, channel_centre_freq;
  logic [3:0] msg_event, raw_correction_msg, periodic_msg, wk;
  logic [3:0] version_report_msg, info_text_msgs, raw_s, ver_s, inf_s;
  logic [1:0] power_state;
  logic [15:0] correction_bit_rate, service_identifier;
  int failures, checked, cnt[4];
  row_t rows[8];

  rcv_cfg_wake i_rcv_cfg_wake (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_interrupt_pin(wk[1:0]),
    .primary_serial_rx(wk[2]), .reset_pin_low(wk[3]), .usb_host_attached,
    .frame_detected, .msg_event, .raw_correction_msg, .periodic_msg,
    .version_report_msg, .info_text_msgs, .ack_reply, .nak_reply,
    .channel_centre_freq, .correction_bit_rate, .service_identifier,
    .service_filter_on, .descramble_on, .prescramble_on, .power_state,
    .core_clock_gate);
  host_apb_model i_host_apb_model (.pclk, .prdata, .pready, .pslverr,
    .psel, .penable, .pwrite, .paddr, .pwdata);

  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (clr) begin
      raw_s <= 4'h0;
      ver_s <= 4'h0;
      inf_s <= 4'h0;
      cnt <= '{0, 0, 0, 0};
    end else begin
      raw_s <= raw_s | raw_correction_msg;
      ver_s <= ver_s | version_report_msg;
      inf_s <= inf_s | info_text_msgs;
      for (int p = 0; p < 4; p++) cnt[p] <= cnt[p] + periodic_msg[p];
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] x, g);
    checked++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, x, g);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host_apb_model.xfer(1'h1, a, d, q, e);
  endtask : wr
  task automatic clear;
    clr <= 1'h1;
    @(posedge pclk);
    clr <= 1'h0;
  endtask : clear
  task automatic sleep_wake(input logic [31:0] ms, input int hold,
      input logic [3:0] m);
    wr(power_off, ms);
    i_host_apb_model.command(4'h0, 32'h0, cmd_power_request, q);
    repeat (4) @(posedge pclk);
    chk("sleep", 32'h3, {30'h0, power_state});
    chk("gate", {31'h0, !usb_host_attached}, {31'h0, core_clock_gate});
    wk <= wk ^ m;
    repeat (hold) @(posedge pclk);
    chk("wake", 32'h0, {30'h0, power_state});
  endtask : sleep_wake
  initial begin
    repeat (80000) @(posedge pclk);
    failures++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, clr, usb_host_attached} = 3'h0;
    wk = 4'h8;
    frame_detected = 1'h0;
    msg_event = 4'h0;
    rows = '{'{key_centre_freq, 32'd1525000000, 2'h1, 32'd1525000000, 2400},
      '{key_centre_freq, 32'd1524999999, 2'h2, 32'd1525000000, 2400},
      '{key_centre_freq, 32'd1559000000, 2'h1, 32'd1559000000, 2400},
      '{key_centre_freq, 32'd1559000001, 2'h2, 32'd1559000000, 2400},
      '{key_bit_rate, 32'd600, 2'h1, 32'd1559000000, 600},
      '{key_bit_rate, 32'd599, 2'h2, 32'd1559000000, 600},
      '{key_bit_rate, 32'd4800, 2'h1, 32'd1559000000, 4800},
      '{key_bit_rate, 32'd4801, 2'h2, 32'd1559000000, 4800}};
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    chk("freq", 32'd1539812500, channel_centre_freq);
    chk("sid", 32'd50821, {16'h0, service_identifier});
    chk("rate", 32'd2400, {16'h0, correction_bit_rate});
    chk("flags", 32'h6, {service_filter_on, descramble_on, prescramble_on});
    i_host_apb_model.command(key_serial_baud, 32'h0, cmd_get, q);
    i_host_apb_model.xfer(1'h0, val_off, 32'h0, q, e);
    chk("baud", 32'd9600, q);
    foreach (rows[i]) begin
      i_host_apb_model.command(rows[i].k, rows[i].v, cmd_set, q);
      chk("reply", {30'h0, rows[i].r}, q);
      chk("freq", rows[i].f, channel_centre_freq);
      chk("rate", {16'h0, rows[i].b}, {16'h0, correction_bit_rate});
    end
    i_host_apb_model.command(key_centre_freq, 32'h0, cmd_delete, q);
    chk("del", 32'd1539812500, channel_centre_freq);
    wr(rate_off, 32'h0000_3102);
    clear();
    repeat (4) begin
      msg_event <= 4'hF;
      @(posedge pclk);
      msg_event <= 4'h0;
      repeat (2) @(posedge pclk);
    end
    chk("periodic", 32'h0200_0401, {cnt[0][7:0], cnt[1][7:0], cnt[2][7:0], cnt[3][7:0]});
    wr(outprot_off, 32'h0000_00FE);
    wr(info_off, 32'h0000_0005);
    frame_detected <= 1'h1;
    @(posedge pclk);
    frame_detected <= 1'h0;
    repeat (3) @(posedge pclk);
    chk("raw", 32'hE, {28'h0, raw_s});
    chk("unpolled", 32'h0, {28'h0, ver_s});
    clear();
    i_host_apb_model.command(4'h0, 32'h0, cmd_version_poll, q);
    chk("version", 32'hE, {28'h0, ver_s});
    chk("info", 32'h4, {28'h0, inf_s});
    sleep_wake(32'h0, 8, 4'h4);
    wk <= 4'h0;
    repeat (8) @(posedge pclk);
    chk("awake", 32'h0, {30'h0, power_state});
    sleep_wake(32'h2, 40050, 4'h0);
    sleep_wake(32'h0, 8, 4'h8);
    usb_host_attached <= 1'h1;
    sleep_wake(32'h0, 20050, 4'h3);
    wr(val_off, 32'd1200);
    wr(nvm_off, 32'h0400_0000);
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    chk("nvm", 32'd1200, {16'h0, correction_bit_rate});
    i_host_apb_model.xfer(1'h0, 12'h0FC, 32'h0, q, e);
    chk("slverr", 32'h1, {31'h0, e});
    conclude();
  end
endmodule : receiver_config_and_wake_control_bench
